/* File: hdl/qur_pkg.sv */
// Purpose: Shared constants and types for one channel of the quad serial port.
// Assumes: Register offsets are byte addresses on a 32-bit Avalon-MM slave.
// Notes: Only the low byte of each word is used; upper bits read as zero.
package qur_pkg;
	// Register byte offsets
	localparam logic [5:0] OFF_DATA = 6'h00;
	localparam logic [5:0] OFF_IEN = 6'h04;
	localparam logic [5:0] OFF_ISTAT = 6'h08;
	localparam logic [5:0] OFF_LCTL = 6'h0C;
	localparam logic [5:0] OFF_MCTL = 6'h10;
	localparam logic [5:0] OFF_LSTAT = 6'h14;
	localparam logic [5:0] OFF_MSTAT = 6'h18;
	localparam logic [5:0] OFF_SCRATCH = 6'h1C;
	localparam logic [5:0] OFF_DIV_LO = 6'h20;
	localparam logic [5:0] OFF_DIV_HI = 6'h24;
	localparam logic [5:0] OFF_EVT_STAT = 6'h28;
	localparam logic [5:0] OFF_EVT_MASK = 6'h2C;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ISTAT = 8'h01;
	localparam logic [7:0] RST_LSTAT = 8'h60;
	localparam logic [7:0] RST_SCRATCH = 8'hFF;
	// Interrupt status codes, highest priority first
	localparam logic [3:0] ISC_LINE = 4'h6;
	localparam logic [3:0] ISC_RXDATA = 4'h4;
	localparam logic [3:0] ISC_THRE = 4'h2;
	localparam logic [3:0] ISC_MODEM = 4'h0;
	localparam logic [3:0] ISC_NONE = 4'h1;
	// Field positions
	localparam int IEN_RX = 0;
	localparam int IEN_THRE = 1;
	localparam int IEN_LINE = 2;
	localparam int IEN_MODEM = 3;
	localparam int MCTL_DTR = 0;
	localparam int MCTL_RTS = 1;
	localparam int MCTL_OP1 = 2;
	localparam int MCTL_INTEN = 3;
	localparam int MCTL_LOOP = 4;
	localparam int LCTL_BREAK = 6;
	localparam int FCTL_FIFO = 0;
	// Sticky event bits
	localparam int EVT_RX = 0;
	localparam int EVT_LINE_ERR = 1;
	localparam int EVT_MODEM = 2;
	localparam int EVT_TX_IDLE = 3;
	localparam int EVT_W = 4;
	// Timing: baud clock is 16 times the bit rate
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] IR_PULSE = 4'h3;
	localparam logic [2:0] RX_LAST_BIT = 3'h7;
	localparam logic [3:0] TX_LAST_SHIFT = 4'h9;
	typedef enum logic [1:0] {QUR_RX_IDLE, QUR_RX_START, QUR_RX_DATA, QUR_RX_STOP} qur_rx_state_t;
endpackage

/* File: hdl/qur_rx_if.sv */
// Purpose: Carries baud tick and line level to the receiver and received characters to the core.
// Assumes: All signals are on ref_clk.
// Notes: valid is a one-cycle pulse at the stop-bit sample.
`timescale 1ns/1ps
interface qur_rx_if;
	logic tick;
	logic line;
	logic valid;
	logic [7:0] data;
	logic frame_err;
	logic brk;
	modport rx (input tick, input line, output valid, output data, output frame_err, output brk);
	modport core (output tick, output line, input valid, input data, input frame_err, input brk);
endinterface

/* File: hdl/qur_sync2.sv */
// Purpose: Two-stage synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes: No reset, so pin levels flow through even while reset is held.
`timescale 1ns/1ps
module qur_sync2 #(
	parameter int W = 1
) (
	// Clock
	input wire logic ref_clk,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge ref_clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule

/* File: hdl/qur_rx.sv */
// Purpose: Serial receiver, 8 data bits, one stop bit, 16x oversampled.
// Assumes: Line input is already synchronised.
// Notes: A start bit shorter than half a bit is treated as a glitch.
`timescale 1ns/1ps
module qur_rx (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Core side
	qur_rx_if.rx rif
);
	qur_pkg::qur_rx_state_t state_r;
	logic [3:0] sub_r;
	logic [2:0] bit_r;
	logic [7:0] shift_r;

	// Pulse coincides with the stop-bit sample
	assign rif.valid = rif.tick && (state_r == qur_pkg::QUR_RX_STOP) && (sub_r == qur_pkg::OVS_LAST);
	assign rif.data = shift_r;
	assign rif.frame_err = !rif.line;
	assign rif.brk = !rif.line && (shift_r == qur_pkg::RST_ZERO);

	// Bit framing, advanced on baud ticks only
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_r <= qur_pkg::QUR_RX_IDLE;
			sub_r <= 4'h0;
			bit_r <= 3'h0;
			shift_r <= 8'h00;
		end else if (rif.tick) begin
			sub_r <= sub_r + 4'h1;
			case (state_r)
				qur_pkg::QUR_RX_IDLE: begin
					sub_r <= 4'h0;
					if (!rif.line) begin
						state_r <= qur_pkg::QUR_RX_START;
					end
				end
				qur_pkg::QUR_RX_START: begin
					if (sub_r == qur_pkg::OVS_MID) begin
						sub_r <= 4'h0;
						bit_r <= 3'h0;
						state_r <= rif.line ? qur_pkg::QUR_RX_IDLE : qur_pkg::QUR_RX_DATA;
					end
				end
				qur_pkg::QUR_RX_DATA: begin
					if (sub_r == qur_pkg::OVS_LAST) begin
						shift_r <= {rif.line, shift_r[7:1]};
						bit_r <= bit_r + 3'h1;
						if (bit_r == qur_pkg::RX_LAST_BIT) begin
							state_r <= qur_pkg::QUR_RX_STOP;
						end
					end
				end
				default: begin
					if (sub_r == qur_pkg::OVS_LAST) begin
						state_r <= qur_pkg::QUR_RX_IDLE;
					end
				end
			endcase
		end
	end

	chk_rx_stop_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rif.valid |=> state_r == qur_pkg::QUR_RX_IDLE) else $error("receiver did not return to idle"); // R07
endmodule

/* File: hdl/qur_chan.sv */
// Purpose: One serial channel: register file, reset state, baud, transmit, interrupts.
// Assumes: Avalon-MM slave with waitrequest; byte lane 0 carries register data.
// Notes: The divisor flops have no reset, so a reset keeps the baud rate.
`timescale 1ns/1ps
// Functional notes
// R01 - Reset clears enable, fifo, line and modem control; status 01, line 60, scratch FF.
// R02 - Reset leaves both divisor bytes as they were; only host writes change them.
// R03 - Divisor is undefined after power-up; host programs it before using the baud rate.
// R04 - In reset modem deltas read zero and upper bits show inverted modem pins.
// R05 - Sixteen mode, style select low: interrupt pin is released after reset.
// R06 - Sixteen mode, style select high: interrupt pin driven low, inactive, after reset.
// R07 - Receive interrupt raised within one baud clock after the stop-bit sample.
// R08 - Reset drives serial high, infrared low, RTS, DTR, receive-ready high, transmit-ready low.
// R09 - Transmitter-idle bit reads one whenever holding stage and shifter are empty.
// R10 - Board ties style select low whenever the sixty-eight bus mode is used.
module qur_chan (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Straps
	input wire logic bus_mode_68,
	input wire logic interrupt_style_select,
	// Serial and modem pins
	input wire logic serial_in,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic cd_n,
	output logic serial_out,
	output logic infrared_serial_out,
	output logic rts_n,
	output logic dtr_n,
	// Ready pins
	output logic receive_ready_n,
	output logic transmit_ready_n,
	// Interrupts
	output logic uart_int,
	output logic uart_int_oe,
	output logic uart_irq_n,
	output logic event_irq
);
	qur_rx_if rif ();
	logic [6:0] pins_s;
	logic m68, style, rx_pin, cts_s, dsr_s, ri_s, cd_s;
	logic wait_r, take, wr, rd;
	logic [7:0] wbyte, rdata_nxt;
	logic [7:0] ien_r, fctl_r, istat_r, lctl_r, mctl_r, scratch_r, rhr_r, thr_r;
	logic [7:0] div_lo_r, div_hi_r;
	logic [15:0] divisor, baud_cnt_r;
	logic bclk_tick, div_wr, div_steady_r;
	logic dr_r, ovr_r, fe_r, bi_r, thr_full_r, tx_busy_r, tx_line_r;
	logic [8:0] tsr_r;
	logic [3:0] tx_sub_r, tx_bits_r;
	logic [3:0] msr_hi, msr_prev_r, delta_r, delta_set;
	logic [7:0] lstat, mstat, istat_nxt;
	logic thre, temt, temt_prev_r, loop, pending, line_err;
	logic [qur_pkg::EVT_W-1:0] evt_r, evt_mask_r, evt_set;

	// Pins from outside pass two flops first
	qur_sync2 #(.W(7)) u_sync (
		.ref_clk(ref_clk),
		.d({bus_mode_68, interrupt_style_select, serial_in, cts_n, dsr_n, ri_n, cd_n}),
		.q(pins_s)
	);
	assign {m68, style, rx_pin, cts_s, dsr_s, ri_s, cd_s} = pins_s;

	qur_rx u_rx (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.rif(rif)
	);

	// Bus handshake: one wait cycle, access takes effect when waitrequest is low
	assign take = (avs_read || avs_write) && !wait_r;
	assign avs_waitrequest = wait_r;
	assign wr = take && avs_write && avs_byteenable[0];
	assign rd = take && avs_read;
	assign wbyte = avs_writedata[7:0];
	assign loop = mctl_r[qur_pkg::MCTL_LOOP];

	// Baud clock at 16x; divisor of zero behaves as one
	assign divisor = {div_hi_r, div_lo_r};
	assign bclk_tick = (baud_cnt_r + 16'h0001 >= divisor);
	assign div_wr = wr && (avs_address == qur_pkg::OFF_DIV_LO || avs_address == qur_pkg::OFF_DIV_HI);
	assign rif.tick = bclk_tick;
	assign rif.line = loop ? (tx_line_r && !lctl_r[qur_pkg::LCTL_BREAK]) : rx_pin;

	// Modem inputs inverted, or looped back from modem control
	assign msr_hi = loop ? {mctl_r[qur_pkg::MCTL_INTEN], mctl_r[qur_pkg::MCTL_OP1],
		mctl_r[qur_pkg::MCTL_DTR], mctl_r[qur_pkg::MCTL_RTS]} : ~{cd_s, ri_s, dsr_s, cts_s}; // R04
	assign delta_set = {msr_hi[3] ^ msr_prev_r[3], !msr_hi[2] && msr_prev_r[2],
		msr_hi[1] ^ msr_prev_r[1], msr_hi[0] ^ msr_prev_r[0]};
	assign mstat = {msr_hi, delta_r};

	// Line status word
	assign thre = !thr_full_r;
	assign temt = !thr_full_r && !tx_busy_r; // R09
	assign lstat = {fe_r || bi_r, temt, thre, bi_r, fe_r, 1'b0, ovr_r, dr_r};
	assign line_err = ovr_r || fe_r || bi_r;

	// Interrupt source by priority
	assign istat_nxt = {{2{fctl_r[qur_pkg::FCTL_FIFO]}}, 2'b00,
		(ien_r[qur_pkg::IEN_LINE] && line_err) ? qur_pkg::ISC_LINE :
		(ien_r[qur_pkg::IEN_RX] && dr_r) ? qur_pkg::ISC_RXDATA :
		(ien_r[qur_pkg::IEN_THRE] && thre) ? qur_pkg::ISC_THRE :
		(ien_r[qur_pkg::IEN_MODEM] && |delta_r) ? qur_pkg::ISC_MODEM : qur_pkg::ISC_NONE};
	assign pending = !istat_nxt[0]; // R07

	// Sticky events for the system interrupt
	assign evt_set = {temt && !temt_prev_r, |delta_set, rif.valid && (rif.frame_err || dr_r), rif.valid};

	// Read data selection; unmapped addresses read zero
	assign rdata_nxt = (avs_address == qur_pkg::OFF_DATA) ? rhr_r :
		(avs_address == qur_pkg::OFF_IEN) ? ien_r :
		(avs_address == qur_pkg::OFF_ISTAT) ? istat_r :
		(avs_address == qur_pkg::OFF_LCTL) ? lctl_r :
		(avs_address == qur_pkg::OFF_MCTL) ? mctl_r :
		(avs_address == qur_pkg::OFF_LSTAT) ? lstat :
		(avs_address == qur_pkg::OFF_MSTAT) ? mstat :
		(avs_address == qur_pkg::OFF_SCRATCH) ? scratch_r :
		(avs_address == qur_pkg::OFF_DIV_LO) ? div_lo_r :
		(avs_address == qur_pkg::OFF_DIV_HI) ? div_hi_r :
		(avs_address == qur_pkg::OFF_EVT_STAT) ? {4'h0, evt_r} :
		(avs_address == qur_pkg::OFF_EVT_MASK) ? {4'h0, evt_mask_r} : qur_pkg::RST_ZERO;

	// Bus response; read data captured during the wait cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wait_r <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			wait_r <= !((avs_read || avs_write) && wait_r);
			if (avs_read && wait_r) begin
				avs_readdata <= {24'h00_0000, rdata_nxt};
			end
		end
	end

	// Divisor has no reset: a reset pulse must not disturb the baud rate
	always_ff @(posedge ref_clk) begin
		if (wr && avs_address == qur_pkg::OFF_DIV_LO) begin
			div_lo_r <= wbyte; // R02 R03
		end
		if (wr && avs_address == qur_pkg::OFF_DIV_HI) begin
			div_hi_r <= wbyte; // R02 R03
		end
		msr_prev_r <= msr_hi;
	end

	// Baud counter
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			baud_cnt_r <= 16'h0000;
			div_steady_r <= 1'b0;
		end else begin
			baud_cnt_r <= bclk_tick ? 16'h0000 : baud_cnt_r + 16'h0001;
			// A tick restarts the count with the new divisor, so it wins over a write
			div_steady_r <= bclk_tick || (div_steady_r && !div_wr);
		end
	end

	// Control registers and their reset state
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ien_r <= qur_pkg::RST_ZERO; // R01
			fctl_r <= qur_pkg::RST_ZERO; // R01
			lctl_r <= qur_pkg::RST_ZERO; // R01
			mctl_r <= qur_pkg::RST_ZERO; // R01
			scratch_r <= qur_pkg::RST_SCRATCH; // R01
			istat_r <= qur_pkg::RST_ISTAT; // R01
			evt_mask_r <= '0;
		end else begin
			istat_r <= istat_nxt;
			if (wr && avs_address == qur_pkg::OFF_IEN) ien_r <= {4'h0, wbyte[3:0]};
			if (wr && avs_address == qur_pkg::OFF_ISTAT) fctl_r <= wbyte;
			if (wr && avs_address == qur_pkg::OFF_LCTL) lctl_r <= wbyte;
			if (wr && avs_address == qur_pkg::OFF_MCTL) mctl_r <= {3'b000, wbyte[4:0]};
			if (wr && avs_address == qur_pkg::OFF_SCRATCH) scratch_r <= wbyte;
			if (wr && avs_address == qur_pkg::OFF_EVT_MASK) evt_mask_r <= wbyte[qur_pkg::EVT_W-1:0];
		end
	end

	// Receive status; an arriving character wins over a clearing read
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			dr_r <= 1'b0;
			ovr_r <= 1'b0;
			fe_r <= 1'b0;
			bi_r <= 1'b0;
			rhr_r <= qur_pkg::RST_ZERO;
			delta_r <= 4'h0; // R04
			evt_r <= '0;
			temt_prev_r <= 1'b1;
		end else begin
			temt_prev_r <= temt;
			if (rd && avs_address == qur_pkg::OFF_DATA) dr_r <= 1'b0;
			if (rd && avs_address == qur_pkg::OFF_LSTAT) begin
				ovr_r <= 1'b0;
				fe_r <= 1'b0;
				bi_r <= 1'b0;
			end
			if (rif.valid) begin
				rhr_r <= rif.data;
				dr_r <= 1'b1; // R07
				ovr_r <= ovr_r || dr_r;
				fe_r <= rif.frame_err;
				bi_r <= rif.brk;
			end
			delta_r <= ((rd && avs_address == qur_pkg::OFF_MSTAT) ? 4'h0 : delta_r) | delta_set;
			evt_r <= ((wr && avs_address == qur_pkg::OFF_EVT_STAT) ? evt_r & ~wbyte[qur_pkg::EVT_W-1:0] : evt_r)
				| evt_set;
		end
	end

	// Transmitter: start bit on load, then 8 data bits and a stop bit
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			thr_r <= qur_pkg::RST_ZERO;
			thr_full_r <= 1'b0; // R09
			tx_busy_r <= 1'b0; // R09
			tx_line_r <= 1'b1;
			tsr_r <= 9'h1FF;
			tx_sub_r <= 4'h0;
			tx_bits_r <= 4'h0;
		end else begin
			if (bclk_tick && tx_busy_r) begin
				tx_sub_r <= tx_sub_r + 4'h1;
				if (tx_sub_r == qur_pkg::OVS_LAST) begin
					if (tx_bits_r == qur_pkg::TX_LAST_SHIFT) begin
						tx_busy_r <= 1'b0;
					end else begin
						tx_line_r <= tsr_r[0];
						tsr_r <= {1'b1, tsr_r[8:1]};
						tx_bits_r <= tx_bits_r + 4'h1;
					end
				end
			end else if (bclk_tick && thr_full_r) begin
				tsr_r <= {1'b1, thr_r};
				tx_line_r <= 1'b0;
				tx_busy_r <= 1'b1;
				thr_full_r <= 1'b0;
				tx_sub_r <= 4'h0;
				tx_bits_r <= 4'h0;
			end
			// Host write comes last so a byte written during a load is not lost
			if (wr && avs_address == qur_pkg::OFF_DATA) begin
				thr_r <= wbyte;
				thr_full_r <= 1'b1;
			end
		end
	end

	// Pin drivers; loopback parks the serial, infrared, RTS and DTR outputs in their idle state
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			serial_out <= 1'b1; // R08
			infrared_serial_out <= 1'b0; // R08
			rts_n <= 1'b1; // R08
			dtr_n <= 1'b1; // R08
			receive_ready_n <= 1'b1; // R08
			transmit_ready_n <= 1'b0; // R08
			uart_int <= 1'b0; // R06
			uart_int_oe <= 1'b0; // R05
			uart_irq_n <= 1'b1; // R08
			event_irq <= 1'b0;
		end else begin
			serial_out <= loop || (tx_line_r && !lctl_r[qur_pkg::LCTL_BREAK]);
			infrared_serial_out <= !loop && !tx_line_r && (tx_sub_r < qur_pkg::IR_PULSE);
			rts_n <= loop || !mctl_r[qur_pkg::MCTL_RTS];
			dtr_n <= loop || !mctl_r[qur_pkg::MCTL_DTR];
			receive_ready_n <= !dr_r;
			transmit_ready_n <= !thre;
			uart_int <= !m68 && pending; // R07
			uart_int_oe <= !m68 && (style || mctl_r[qur_pkg::MCTL_INTEN]); // R05 R06 R10
			uart_irq_n <= !(m68 && pending);
			event_irq <= |(evt_r & evt_mask_r);
		end
	end

	// Checks
	sequence stop_seen;
		rif.valid && ien_r[qur_pkg::IEN_RX] && !ien_r[qur_pkg::IEN_LINE];
	endsequence
	sequence rx_raised;
		##1 istat_r[3:0] == qur_pkg::ISC_RXDATA && (uart_int || m68);
	endsequence

	chk_reset_regs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R01
		$rose(rst_b) |-> ien_r == 8'h00 && fctl_r == 8'h00 && lctl_r == 8'h00 && mctl_r == 8'h00
		&& istat_r == 8'h01 && lstat == 8'h60 && scratch_r == 8'hFF) else $error("reset register values wrong");
	chk_divisor_kept: assert property (@(posedge ref_clk) // R02
		$changed(divisor) |-> $past(div_wr)) else $error("divisor changed without a host write");
	chk_baud_period: assert property (@(posedge ref_clk) disable iff (!rst_b) // R03
		bclk_tick && div_steady_r && divisor > 16'h0001 |-> baud_cnt_r == divisor - 16'h0001)
		else $error("baud tick early");
	chk_modem_reset: assert property (@(posedge ref_clk) disable iff (!rst_b) // R04
		$rose(rst_b) && !loop |-> mstat[3:0] == 4'h0 && mstat[7:4] == ~{cd_s, ri_s, dsr_s, cts_s})
		else $error("modem status wrong after reset");
	chk_int_float: assert property (@(posedge ref_clk) disable iff (!rst_b) // R05
		!m68 && !style && !mctl_r[qur_pkg::MCTL_INTEN] |=> !uart_int_oe) else $error("interrupt pin driven");
	chk_int_driven: assert property (@(posedge ref_clk) disable iff (!rst_b) // R06
		$rose(rst_b) && !m68 && style |-> !uart_int ##1 uart_int_oe && !uart_int) else $error("interrupt pin not low");
	chk_rx_int: assert property (@(posedge ref_clk) disable iff (!rst_b) // R07
		stop_seen |=> rx_raised) else $error("receive interrupt late");
	chk_pins_reset: assert property (@(posedge ref_clk) disable iff (!rst_b) // R08
		$rose(rst_b) |-> serial_out && !infrared_serial_out && rts_n && dtr_n && receive_ready_n
		&& !transmit_ready_n && uart_irq_n) else $error("pin reset state wrong");
	chk_tx_idle: assert property (@(posedge ref_clk) disable iff (!rst_b) // R09
		$fell(lstat[6]) |-> $past(wr) && tx_busy_r || thr_full_r) else $error("idle bit dropped while empty");
endmodule

/* File: verification/qur_peer.sv */
// Purpose: Far end of the serial line, sending whole 8N1 characters into the channel.
// Assumes: Bit time is sixteen baud ticks of div ref_clk cycles each.
// Notes: Line idles at mark; a send returns at the middle of its stop bit.
`timescale 1ns/1ps
module qur_peer (
	// Clock
	input wire logic ref_clk,
	// Serial line towards the channel
	output logic line
);
	// Mark from time zero so the receiver never sees a false start
	initial begin
		line = 1'b1;
	end
	// Least significant bit first; return early so the caller can time the stop-bit sample
	task automatic send(input logic [7:0] b, input int div);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			line <= frame[i];
			repeat ((i == 9 ? 8 : 16) * div - 1) @(posedge ref_clk);
		end
	endtask
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for one channel: reset state, divisor keep, receive timing, events.
// Assumes: One wait cycle per bus access; registers mirrored in a small bench model.
// Notes: Receive latency bound allows for pin synchronisers and start-bit detection.
`timescale 1ns/1ps
module tb;
	logic ref_clk;
	logic rst_b;
	logic [5:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, seed, rd;
	logic [3:0] avs_byteenable;
	logic bus_mode_68, interrupt_style_select;
	logic serial_in, cts_n, dsr_n, ri_n, cd_n, saw_low;
	logic serial_out, infrared_serial_out, rts_n, dtr_n, receive_ready_n, transmit_ready_n;
	logic uart_int, uart_int_oe, uart_irq_n, event_irq;
	logic [7:0] mdl [0:15];
	logic [7:0] rxq [$];
	int err_total, checks_done, n;
	localparam logic [5:0] ROFF [0:6] = '{qur_pkg::OFF_IEN, qur_pkg::OFF_ISTAT, qur_pkg::OFF_LCTL,
		qur_pkg::OFF_MCTL, qur_pkg::OFF_LSTAT, qur_pkg::OFF_MSTAT, qur_pkg::OFF_SCRATCH};
	localparam logic [5:0] WOFF [0:5] = '{qur_pkg::OFF_DIV_LO, qur_pkg::OFF_DIV_HI, qur_pkg::OFF_IEN,
		qur_pkg::OFF_LCTL, qur_pkg::OFF_MCTL, qur_pkg::OFF_SCRATCH};

	qur_chan uut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_mode_68(bus_mode_68),
		.interrupt_style_select(interrupt_style_select), .serial_in(serial_in), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .serial_out(serial_out),
		.infrared_serial_out(infrared_serial_out), .rts_n(rts_n), .dtr_n(dtr_n),
		.receive_ready_n(receive_ready_n), .transmit_ready_n(transmit_ready_n), .uart_int(uart_int),
		.uart_int_oe(uart_int_oe), .uart_irq_n(uart_irq_n), .event_irq(event_irq));
	qur_peer peer (.ref_clk(ref_clk), .line(serial_in));

	// Free-running 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Remember whether the transmitter ever left mark
	always @(posedge ref_clk) begin
		if (serial_out === 1'b0) begin
			saw_low <= 1'b1;
		end
	end
	// Shift-xor generator, fixed seed
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// What a write leaves readable: unused upper bits read zero
	function automatic logic [7:0] keep(input logic [5:0] a, input logic [7:0] d);
		case (a)
			qur_pkg::OFF_IEN, qur_pkg::OFF_EVT_MASK: keep = d & 8'h0F;
			qur_pkg::OFF_MCTL: keep = d & 8'h1F;
			default: keep = d;
		endcase
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("Comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One Avalon-MM access, held until waitrequest is sampled low; only the watchdog ends a hang
	task bus(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= be;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task mwr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
		mdl[a >> 2] = keep(a, d);
	endtask
	task mrd(input logic [5:0] a);
		bus(1'b0, a, 8'h00, 4'h0);
		chk(rd, {24'h00_0000, mdl[a >> 2]});
	endtask
	// Reset for six cycles, checking pins while held; the model keeps only the divisor
	task do_reset;
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk({22'h00_0000, serial_out, infrared_serial_out, rts_n, dtr_n, receive_ready_n, transmit_ready_n,
			uart_int_oe, uart_irq_n, event_irq, uart_int}, 32'h0000_02E4);
		rst_b <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			if (i != (qur_pkg::OFF_DIV_LO >> 2) && i != (qur_pkg::OFF_DIV_HI >> 2)) begin
				mdl[i] = 8'h00;
			end
		end
		mdl[qur_pkg::OFF_ISTAT >> 2] = qur_pkg::RST_ISTAT;
		mdl[qur_pkg::OFF_LSTAT >> 2] = qur_pkg::RST_LSTAT;
		mdl[qur_pkg::OFF_SCRATCH >> 2] = qur_pkg::RST_SCRATCH;
		mdl[qur_pkg::OFF_MSTAT >> 2] = {~{cd_n, ri_n, dsr_n, cts_n}, 4'h0};
	endtask

	// Watchdog: the whole sequence needs about a thousand cycles
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_total++;
		close_out;
	end

	initial begin
		err_total = 0;
		checks_done = 0;
		seed = 32'h0000_8901;
		rst_b = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		bus_mode_68 = 1'b0;
		interrupt_style_select = 1'b0;
		saw_low = 1'b0;
		rd = xs();
		{cd_n, ri_n, dsr_n, cts_n} = rd[3:0];
		do_reset;
		// Reset values of the register file, modem status from live pins
		for (int i = 0; i < 7; i++) mrd(ROFF[i]);
		// Random programming, then a second reset: divisor survives, the rest returns to reset value
		for (int i = 0; i < 6; i++) begin
			rd = xs();
			mwr(WOFF[i], rd[7:0] & (WOFF[i] == qur_pkg::OFF_LCTL ? 8'hBF : 8'hFF) & 
				(WOFF[i] == qur_pkg::OFF_MCTL ? 8'h0F : 8'hFF));
		end
		for (int i = 0; i < 6; i++) mrd(WOFF[i]);
		do_reset;
		for (int i = 0; i < 6; i++) mrd(WOFF[i]);
		// Unmapped place and disabled byte lane are both ignored
		bus(1'b1, 6'h3C, 8'hA5, 4'h1);
		bus(1'b0, 6'h3C, 8'h00, 4'h0);
		chk(rd, 32'h0000_0000);
		bus(1'b1, qur_pkg::OFF_SCRATCH, 8'h12, 4'h2);
		mrd(qur_pkg::OFF_SCRATCH);
		// Receive one character and time the interrupt against the stop bit
		mwr(qur_pkg::OFF_DIV_LO, 8'h04);
		mwr(qur_pkg::OFF_DIV_HI, 8'h00);
		mwr(qur_pkg::OFF_IEN, 8'h01);
		mwr(qur_pkg::OFF_MCTL, 8'h08);
		mwr(qur_pkg::OFF_EVT_MASK, 8'h01);
		rd = xs();
		rxq.push_back(rd[7:0]);
		peer.send(rxq[0], 4);
		n = 0;
		while (uart_int !== 1'b1 && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
		chk({31'h0000_0000, n <= 12}, 32'h0000_0001);
		chk({30'h0000_0000, receive_ready_n, event_irq}, 32'h0000_0001);
		bus(1'b0, qur_pkg::OFF_ISTAT, 8'h00, 4'h0);
		chk(rd, {28'h000_0000, qur_pkg::ISC_RXDATA});
		bus(1'b0, qur_pkg::OFF_DATA, 8'h00, 4'h0);
		chk(rd, {24'h00_0000, rxq.pop_front()});
		mrd(qur_pkg::OFF_ISTAT);
		// Event interrupt masked, unmasked, then cleared by writing ones
		mwr(qur_pkg::OFF_EVT_MASK, 8'h00);
		repeat (2) @(posedge ref_clk);
		chk({31'h0000_0000, event_irq}, 32'h0000_0000);
		mwr(qur_pkg::OFF_EVT_MASK, 8'h01);
		repeat (2) @(posedge ref_clk);
		chk({31'h0000_0000, event_irq}, 32'h0000_0001);
		bus(1'b1, qur_pkg::OFF_EVT_STAT, 8'h0F, 4'h1);
		repeat (2) @(posedge ref_clk);
		chk({31'h0000_0000, event_irq}, 32'h0000_0000);
		// Transmit: idle flag drops while busy and returns when shifter and holding stage empty
		mwr(qur_pkg::OFF_DIV_LO, 8'h01);
		saw_low <= 1'b0;
		bus(1'b1, qur_pkg::OFF_DATA, 8'h55, 4'h1);
		bus(1'b0, qur_pkg::OFF_LSTAT, 8'h00, 4'h0);
		chk({31'h0000_0000, rd[6]}, 32'h0000_0000);
		n = 0;
		do begin
			bus(1'b0, qur_pkg::OFF_LSTAT, 8'h00, 4'h0);
			n++;
		end while (rd[6] !== 1'b1 && n < 200);
		chk(rd, {24'h00_0000, qur_pkg::RST_LSTAT});
		chk({30'h0000_0000, saw_low, transmit_ready_n}, 32'h0000_0002);
		// Style select high: interrupt pin driven and low after reset
		interrupt_style_select <= 1'b1;
		do_reset;
		repeat (3) @(posedge ref_clk);
		chk({30'h0000_0000, uart_int_oe, uart_int}, 32'h0000_0002);
		// Sixty-eight bus mode needs style select tied low
		interrupt_style_select <= 1'b0;
		bus_mode_68 <= 1'b1;
		do_reset;
		repeat (3) @(posedge ref_clk);
		chk({31'h0000_0000, uart_irq_n}, 32'h0000_0001);
		mrd(qur_pkg::OFF_SCRATCH);
		close_out;
	end
endmodule
